// [ivfr_consts.svh]
// constants for the input voltage supervision block: command codes, field positions,
// reset values and timing counts; assumes a 25 MHz sys_clk
`ifndef IVFR_CONSTS_SVH
`define IVFR_CONSTS_SVH

`define IVFR_CMD_OPERATION    8'h01
`define IVFR_CMD_CLEAR_FAULTS 8'h03
`define IVFR_CMD_HIGH_WARN    8'h57
`define IVFR_CMD_LOW_WARN     8'h58
`define IVFR_CMD_LOW_FAULT    8'h59
`define IVFR_CMD_LOW_ACTION   8'h5a
`define IVFR_CMD_STATUS_INPUT 8'h7c
`define IVFR_CMD_DELAY_UNIT   8'hd2
`define IVFR_CMD_VENDOR_OPTS  8'he0

`define IVFR_ACT_TYPE_HI      7
`define IVFR_ACT_TYPE_LO      6
`define IVFR_ACT_RETRY_HI     5
`define IVFR_ACT_RETRY_LO     3
`define IVFR_ACT_DELAY_HI     2
`define IVFR_ACT_DELAY_LO     0
`define IVFR_OPER_ON_BIT      7
`define IVFR_OPTS_RATIO_BIT   0
`define IVFR_STS_HIGH_WARN    6
`define IVFR_STS_LOW_WARN     5
`define IVFR_STS_LOW_FAULT    4

`define IVFR_RST_HIGH_WARN    16'hd370
`define IVFR_RST_LOW_WARN     16'hd2c0
`define IVFR_RST_LOW_FAULT    16'hd2a0
`define IVFR_RST_LOW_ACTION   8'h80
`define IVFR_RST_DELAY_UNIT   16'h0000
`define IVFR_RST_OPERATION    8'h80
`define IVFR_RST_VENDOR_OPTS  8'h00

`define IVFR_RETRY_NONE       3'h0
`define IVFR_RETRY_FOREVER    3'h7

// delay unit register holds (value + 1) base steps of this length
`define IVFR_BASE_STEP_NS     1000
`define IVFR_CLK_MHZ          25
`define IVFR_BASE_STEP_CYC    ((`IVFR_BASE_STEP_NS * `IVFR_CLK_MHZ) / 1000)

`endif

// [ivfr_pkg.sv]
// types for the input voltage supervision block
// assumes ivfr_consts.svh supplies the numeric constants
package ivfr_pkg;
    // gray along run -> delay -> wait -> latched
    typedef enum logic [1:0] {
        IVFR_RUN   = 2'b00,
        IVFR_DELAY = 2'b01,
        IVFR_WAIT  = 2'b11,
        IVFR_LATCH = 2'b10
    } ivfr_state_e;

    typedef logic [15:0] ivfr_word_t;
endpackage

// [ivfr_core.sv]
// input voltage thresholds, status and under-voltage fault response
// assumes commands arrive already decoded from the management bus, one per strobe,
// and that input samples come from logic on sys_clk; run_pin is an outside pin
`include "ivfr_consts.svh"
`timescale 1ns/1ps

module ivfr_core (
    input  wire logic        sys_clk,         // 25 MHz clock
    input  wire logic        reset_n,         // synchronous reset, also bias loss
    input  wire logic        cmd_valid,       // one-cycle command strobe
    input  wire logic        cmd_write,       // 1 write, 0 read
    input  wire logic [7:0]  cmd_code,        // command code
    input  wire logic [15:0] cmd_wdata,       // write data, bytes in low bits
    input  wire logic        vin_valid,       // new input voltage sample
    input  wire logic [15:0] vin_sample,      // measured input voltage, linear
    input  wire logic        run_pin,         // control pin, high = run
    output logic      [15:0] rsp_rdata_r,     // read data, valid cycle after read
    output logic             output_on_r,     // converter output enable
    output logic             low_fault_r,     // input under-voltage fault present
    output logic             ratio_regulation_switchover_r // ratio mode active
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    ivfr_pkg::ivfr_word_t  high_warn_r, high_warn_nxt;
    ivfr_pkg::ivfr_word_t  low_warn_r, low_warn_nxt;
    ivfr_pkg::ivfr_word_t  low_fault_thr_r, low_fault_thr_nxt;
    ivfr_pkg::ivfr_word_t  delay_unit_r, delay_unit_nxt;
    ivfr_pkg::ivfr_word_t  unit_cnt_r, unit_cnt_nxt;
    ivfr_pkg::ivfr_word_t  rdata_nxt;
    ivfr_pkg::ivfr_state_e state_r, state_nxt;
    logic [7:0]  action_r, action_nxt;
    logic [7:0]  operation_r, operation_nxt;
    logic [7:0]  opts_r, opts_nxt;
    logic [7:0]  status_r, status_nxt;
    logic [7:0]  units_r, units_nxt;
    logic [4:0]  step_cnt_r, step_cnt_nxt;
    logic [2:0]  tries_r, tries_nxt;
    logic [1:0]  run_sync_r;
    logic        run_cmd_r, run_cmd_nxt;
    logic        on_nxt, fault_nxt, ratio_nxt;

    logic        wr, rd, run_cmd, clear_evt, unit_tick, delay_done, retry_left;
    logic [1:0]  act_type;
    logic [2:0]  act_retry;
    logic [7:0]  act_units;
    logic [7:0]  sts_set;

    ////////////////////////////////////////////////////////////////////////////
    // datapath and response machine

    always_comb begin
        wr        = cmd_valid & cmd_write;
        rd        = cmd_valid & ~cmd_write;
        act_type  = action_r[`IVFR_ACT_TYPE_HI:`IVFR_ACT_TYPE_LO];
        act_retry = action_r[`IVFR_ACT_RETRY_HI:`IVFR_ACT_RETRY_LO];
        act_units = 8'h01 << action_r[`IVFR_ACT_DELAY_HI:`IVFR_ACT_DELAY_LO];
        run_cmd   = operation_r[`IVFR_OPER_ON_BIT] & run_sync_r[1];

        high_warn_nxt     = high_warn_r;
        low_warn_nxt      = low_warn_r;
        low_fault_thr_nxt = low_fault_thr_r;
        action_nxt        = action_r;
        delay_unit_nxt    = delay_unit_r;
        operation_nxt     = operation_r;
        opts_nxt          = opts_r;
        rdata_nxt         = rsp_rdata_r;
        clear_evt         = 1'b0;
        if (wr) begin
            unique case (cmd_code)
                `IVFR_CMD_HIGH_WARN:    high_warn_nxt     = cmd_wdata;
                `IVFR_CMD_LOW_WARN:     low_warn_nxt      = cmd_wdata;
                `IVFR_CMD_LOW_FAULT:    low_fault_thr_nxt = cmd_wdata;
                `IVFR_CMD_LOW_ACTION:   action_nxt        = cmd_wdata[7:0];
                `IVFR_CMD_DELAY_UNIT:   delay_unit_nxt    = cmd_wdata;
                `IVFR_CMD_OPERATION:    operation_nxt     = cmd_wdata[7:0];
                `IVFR_CMD_VENDOR_OPTS:  opts_nxt          = cmd_wdata[7:0];
                `IVFR_CMD_CLEAR_FAULTS: clear_evt         = 1'b1;
                default: ;
            endcase
        end
        if (rd) begin
            unique case (cmd_code)
                `IVFR_CMD_HIGH_WARN:    rdata_nxt = high_warn_r;
                `IVFR_CMD_LOW_WARN:     rdata_nxt = low_warn_r;
                `IVFR_CMD_LOW_FAULT:    rdata_nxt = low_fault_thr_r;
                `IVFR_CMD_LOW_ACTION:   rdata_nxt = {8'h00, action_r};
                `IVFR_CMD_DELAY_UNIT:   rdata_nxt = delay_unit_r;
                `IVFR_CMD_OPERATION:    rdata_nxt = {8'h00, operation_r};
                `IVFR_CMD_VENDOR_OPTS:  rdata_nxt = {8'h00, opts_r};
                `IVFR_CMD_STATUS_INPUT: rdata_nxt = {8'h00, status_r};
                default:                rdata_nxt = 16'h0000;
            endcase
        end

        // threshold compares; raw compare assumes all words share one exponent
        fault_nxt = low_fault_r;
        ratio_nxt = ratio_regulation_switchover_r;
        sts_set   = 8'h00;
        if (vin_valid) begin
            fault_nxt = vin_sample < low_fault_thr_r;
            ratio_nxt = opts_r[`IVFR_OPTS_RATIO_BIT] & (vin_sample >= low_warn_r);
            sts_set[`IVFR_STS_HIGH_WARN] = vin_sample > high_warn_r;
            sts_set[`IVFR_STS_LOW_WARN]  = vin_sample < low_warn_r;
            sts_set[`IVFR_STS_LOW_FAULT] = vin_sample < low_fault_thr_r;
        end
        // write-one-to-clear, a new event wins over the clear
        status_nxt = status_r;
        if (wr && cmd_code == `IVFR_CMD_STATUS_INPUT) begin
            status_nxt = status_r & ~cmd_wdata[7:0];
        end
        if (clear_evt) begin
            status_nxt = 8'h00;
        end
        status_nxt = status_nxt | sts_set;
        // individual clear of the fault bit also releases a latched output
        if (wr && cmd_code == `IVFR_CMD_STATUS_INPUT && cmd_wdata[`IVFR_STS_LOW_FAULT]) begin
            clear_evt = 1'b1;
        end
        // going off releases a latch, the output returns when back on; reset covers bias loss
        run_cmd_nxt = run_cmd;
        if (run_cmd_r && !run_cmd) begin
            clear_evt = 1'b1;
        end

        // delay unit timebase: (delay_unit + 1) base steps per unit
        step_cnt_nxt = step_cnt_r + 5'h01;
        unit_cnt_nxt = unit_cnt_r;
        unit_tick    = 1'b0;
        if (step_cnt_r == 5'(`IVFR_BASE_STEP_CYC - 1)) begin
            step_cnt_nxt = 5'h00;
            unit_cnt_nxt = unit_cnt_r + 16'h0001;
            if (unit_cnt_r == delay_unit_r) begin
                unit_cnt_nxt = 16'h0000;
                unit_tick    = 1'b1;
            end
        end
        units_nxt  = unit_tick ? units_r + 8'h01 : units_r;
        delay_done = unit_tick && (units_r + 8'h01 == act_units);
        retry_left = (act_retry == `IVFR_RETRY_FOREVER) || (tries_r < act_retry);

        state_nxt = state_r;
        tries_nxt = tries_r;
        unique case (state_r)
            ivfr_pkg::IVFR_RUN: begin
                units_nxt = 8'h00;
                tries_nxt = 3'h0;
                if (low_fault_r) begin
                    unique case (act_type)
                        2'b00: state_nxt = ivfr_pkg::IVFR_RUN;
                        2'b01: state_nxt = ivfr_pkg::IVFR_DELAY;
                        2'b10: state_nxt = (act_retry == `IVFR_RETRY_NONE) ?
                                   ivfr_pkg::IVFR_LATCH : ivfr_pkg::IVFR_WAIT;
                        2'b11: state_nxt = ivfr_pkg::IVFR_LATCH;
                    endcase
                end
            end
            ivfr_pkg::IVFR_DELAY: begin
                // output stays on while the delay runs
                if (!low_fault_r) begin
                    state_nxt = ivfr_pkg::IVFR_RUN;
                end else if (delay_done) begin
                    units_nxt = 8'h00;
                    state_nxt = (act_retry == `IVFR_RETRY_NONE) ?
                                ivfr_pkg::IVFR_LATCH : ivfr_pkg::IVFR_WAIT;
                end
            end
            ivfr_pkg::IVFR_WAIT: begin
                // each interval end is one restart attempt
                if (delay_done) begin
                    units_nxt = 8'h00;
                    if (!low_fault_r) begin
                        state_nxt = ivfr_pkg::IVFR_RUN;
                    end else if (retry_left) begin
                        if (act_retry != `IVFR_RETRY_FOREVER) begin
                            tries_nxt = tries_r + 3'h1;
                        end
                    end else begin
                        state_nxt = ivfr_pkg::IVFR_LATCH;
                    end
                end
            end
            ivfr_pkg::IVFR_LATCH: begin
                units_nxt = 8'h00;
                if (clear_evt) begin
                    state_nxt = ivfr_pkg::IVFR_RUN;
                end
            end
        endcase
        // commanded off ends an endless retry too
        if (!run_cmd && state_r == ivfr_pkg::IVFR_WAIT) begin
            state_nxt = ivfr_pkg::IVFR_LATCH;
        end
        on_nxt = run_cmd && (state_nxt == ivfr_pkg::IVFR_RUN ||
                             state_nxt == ivfr_pkg::IVFR_DELAY);
    end

    always_ff @(posedge sys_clk) begin
        run_sync_r <= {run_sync_r[0], run_pin};
        if (!reset_n) begin
            high_warn_r                   <= `IVFR_RST_HIGH_WARN;
            low_warn_r                    <= `IVFR_RST_LOW_WARN;
            low_fault_thr_r               <= `IVFR_RST_LOW_FAULT;
            action_r                      <= `IVFR_RST_LOW_ACTION;
            delay_unit_r                  <= `IVFR_RST_DELAY_UNIT;
            operation_r                   <= `IVFR_RST_OPERATION;
            opts_r                        <= `IVFR_RST_VENDOR_OPTS;
            status_r                      <= 8'h00;
            rsp_rdata_r                   <= 16'h0000;
            state_r                       <= ivfr_pkg::IVFR_RUN;
            units_r                       <= 8'h00;
            unit_cnt_r                    <= 16'h0000;
            step_cnt_r                    <= 5'h00;
            tries_r                       <= 3'h0;
            run_cmd_r                     <= 1'b0;
            output_on_r                   <= 1'b0;
            low_fault_r                   <= 1'b0;
            ratio_regulation_switchover_r <= 1'b0;
        end else begin
            high_warn_r                   <= high_warn_nxt;
            low_warn_r                    <= low_warn_nxt;
            low_fault_thr_r               <= low_fault_thr_nxt;
            action_r                      <= action_nxt;
            delay_unit_r                  <= delay_unit_nxt;
            operation_r                   <= operation_nxt;
            opts_r                        <= opts_nxt;
            status_r                      <= status_nxt;
            rsp_rdata_r                   <= rdata_nxt;
            state_r                       <= state_nxt;
            units_r                       <= units_nxt;
            unit_cnt_r                    <= unit_cnt_nxt;
            step_cnt_r                    <= step_cnt_nxt;
            tries_r                       <= tries_nxt;
            run_cmd_r                     <= run_cmd_nxt;
            output_on_r                   <= on_nxt;
            low_fault_r                   <= fault_nxt;
            ratio_regulation_switchover_r <= ratio_nxt;
        end
    end

endmodule

// [ivfr_core_properties.sv]
// checker for the input voltage supervision core: readback, compares, fault response
// assumes it is bound to ivfr_core and sees only that module's ports
`timescale 1ns/1ps

module ivfr_core_properties (
    input wire logic        sys_clk,                      // clock
    input wire logic        reset_n,                      // sync reset, low
    input wire logic        cmd_valid,                    // command strobe
    input wire logic        cmd_write,                    // write select
    input wire logic [7:0]  cmd_code,                     // command code
    input wire logic [15:0] cmd_wdata,                    // write data
    input wire logic        vin_valid,                    // sample strobe
    input wire logic [15:0] vin_sample,                   // input sample
    input wire logic        run_pin,                      // run pin
    input wire logic [15:0] rsp_rdata_r,                  // read data
    input wire logic        output_on_r,                  // output enable
    input wire logic        low_fault_r,                  // fault flag
    input wire logic        ratio_regulation_switchover_r // ratio mode
);
    logic [15:0] warn_r, warn_nxt, flt_r, flt_nxt;
    logic [7:0]  act_r, act_nxt;
    logic        opt_r, opt_nxt, wr, rd;
    // shadow copies of the settings give the properties a reference value
    always_comb begin
        wr = cmd_valid && cmd_write;
        rd = cmd_valid && !cmd_write;
        warn_nxt = (wr && cmd_code == 8'h58) ? cmd_wdata : warn_r;
        flt_nxt = (wr && cmd_code == 8'h59) ? cmd_wdata : flt_r;
        act_nxt = (wr && cmd_code == 8'h5a) ? cmd_wdata[7:0] : act_r;
        opt_nxt = (wr && cmd_code == 8'he0) ? cmd_wdata[0] : opt_r;
    end
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            warn_r <= 16'hd2c0;
            flt_r <= 16'hd2a0;
            act_r <= 8'h80;
            opt_r <= 1'b0;
        end else begin
            warn_r <= warn_nxt;
            flt_r <= flt_nxt;
            act_r <= act_nxt;
            opt_r <= opt_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    AST_FLT_READ: assert property (rd && cmd_code == 8'h59 |=> rsp_rdata_r == $past(flt_r))
        else $error("fault threshold readback wrong");
    AST_WARN_READ: assert property (rd && cmd_code == 8'h58 |=> rsp_rdata_r == $past(warn_r))
        else $error("warning threshold readback wrong");
    AST_ACT_READ: assert property (rd && cmd_code == 8'h5a |=>
        rsp_rdata_r == {8'h00, $past(act_r)})
        else $error("action byte readback wrong");
    AST_FAULT_CMP: assert property (vin_valid && !wr |=>
        low_fault_r == ($past(vin_sample) < flt_r))
        else $error("fault flag does not follow the sample");
    AST_RATIO: assert property (vin_valid && !wr |=>
        ratio_regulation_switchover_r == (opt_r && $past(vin_sample) >= warn_r))
        else $error("ratio switchover wrong");
    AST_IGNORE: assert property (act_r[7:6] == 2'b00 && output_on_r && !cmd_valid &&
        !$past(cmd_valid) |=> output_on_r)
        else $error("output dropped while fault ignored");
    AST_RUN_ON: assert property ($rose(low_fault_r) && act_r[7:6] == 2'b01 &&
        act_r[2:0] == 3'h1 && output_on_r |=> output_on_r [*8])
        else $error("output dropped before the delay");
    AST_DISABLE: assert property ($rose(low_fault_r) && act_r[7:6] == 2'b10 |->
        ##[1:3] !output_on_r)
        else $error("output not disabled on fault");
    AST_NO_RETRY: assert property ($fell(output_on_r) && act_r[7:3] == 5'b10000 |=>
        !output_on_r [*8])
        else $error("restart without retries");
    // a clear command or a pin off/on may legally bring the output back, so those
    // cycles are left out; the pin needs three cycles to pass the sync and the register
    AST_LATCHED: assert property (act_r[7:6] == 2'b11 && !output_on_r && !cmd_valid &&
        !$past(cmd_valid) && $past(run_pin, 3) |=> !output_on_r)
        else $error("latched output came back");
    AST_ONE_TRY: assert property ($fell(low_fault_r) && act_r[7:3] == 5'b10001 |->
        ##30 !output_on_r)
        else $error("restart after the single attempt");
    AST_FOREVER: assert property ($fell(low_fault_r) && act_r == 8'hb8 |->
        ##[1:40] output_on_r)
        else $error("endless retry did not restart");
endmodule

bind ivfr_core ivfr_core_properties u_props (.sys_clk(sys_clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .vin_valid(vin_valid), .vin_sample(vin_sample), .run_pin(run_pin),
    .rsp_rdata_r(rsp_rdata_r), .output_on_r(output_on_r), .low_fault_r(low_fault_r),
    .ratio_regulation_switchover_r(ratio_regulation_switchover_r));

// [ivfr_host_model.sv]
// management host: issues one-cycle command strobes on request
// assumes a single caller process; gap adds idle cycles before a command
`timescale 1ns/1ps

module ivfr_host_model (
    input  wire logic        sys_clk,   // clock
    output logic             cmd_valid, // strobe
    output logic             cmd_write, // write select
    output logic [7:0]       cmd_code,  // code
    output logic [15:0]      cmd_wdata  // data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'hff;
        cmd_wdata = 16'hffff;
    end
    // idle lines show the inverse of the last value so nothing stale looks valid
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        input logic [1:0] gap);
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code = c;
        cmd_wdata = d;
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_write = ~w;
        cmd_code = ~c;
        cmd_wdata = ~d;
    endtask
endmodule

// [tb.sv]
// self-checking bench for the input voltage supervision core
// assumes the host model drives commands and the checker is bound to the core
`timescale 1ns/1ps

module tb;
    logic        sys_clk, reset_n, run_pin, vin_valid, cmd_valid, cmd_write, pend;
    logic        output_on_r, low_fault_r, ratio_r;
    logic [7:0]  cmd_code;
    logic [15:0] vin_sample, rsp_rdata_r, cmd_wdata, d;
    logic [25:0] note_q[$];
    logic [25:0] note;
    logic [9:0]  cases[8];
    integer      seed, n_fail, n_checks, i;

    ivfr_core u_ivfr_core (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .vin_valid(vin_valid), .vin_sample(vin_sample), .run_pin(run_pin),
        .rsp_rdata_r(rsp_rdata_r), .output_on_r(output_on_r), .low_fault_r(low_fault_r),
        .ratio_regulation_switchover_r(ratio_r));
    ivfr_host_model u_host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // expected {ratio, output on, read data} is noted before the read goes out
    task automatic rd(input logic [7:0] c, input logic [17:0] e);
        note_q.push_back({c, e});
        u_host.xfer(1'b0, c, 16'h0000, 2'($random(seed)));
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] v);
        u_host.xfer(1'b1, c, v, 2'($random(seed)));
    endtask
    task automatic vin(input logic [15:0] v);
        @(posedge sys_clk);
        #1;
        vin_valid = 1'b1;
        vin_sample = v;
        @(posedge sys_clk);
        #1;
        vin_valid = 1'b0;
        vin_sample = ~v;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        pend <= cmd_valid && !cmd_write;
    end
    // results are launched by the edge after the read, so look half a cycle later
    always @(negedge sys_clk) begin
        if (pend) begin
            note = note_q.pop_front();
            n_checks = n_checks + 1;
            if ({ratio_r, output_on_r, rsp_rdata_r} !== note[17:0]) begin
                n_fail = n_fail + 1;
                $display("MISMATCH read %h exp %h got %h", note[25:18], note[17:0],
                         {ratio_r, output_on_r, rsp_rdata_r});
            end
        end
    end
    initial begin
        #(40 * 20000);
        n_fail = n_fail + 1;
        close_out;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h3ae3;
        n_fail = 0;
        n_checks = 0;
        pend = 1'b0;
        reset_n = 1'b0;
        run_pin = 1'b1;
        vin_valid = 1'b0;
        vin_sample = 16'h0000;
        // action byte with expected output on while low and after recovery
        cases = '{{2'b11, 8'h00}, {2'b00, 8'h80}, {2'b00, 8'h88}, {2'b00, 8'h98},
                  {2'b01, 8'hb0}, {2'b01, 8'hb8}, {2'b00, 8'h41}, {2'b00, 8'hc0}};
        repeat (12) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        repeat (6) @(posedge sys_clk);
        rd(8'h57, {2'b01, 16'hd370});
        rd(8'h58, {2'b01, 16'hd2c0});
        rd(8'h59, {2'b01, 16'hd2a0});
        rd(8'h5a, {2'b01, 16'h0080});
        rd(8'h10, {2'b01, 16'h0000});
        for (i = 0; i < 3; i++) begin
            d = 16'($random(seed));
            wr(8'h57 + i[7:0], d);
            rd(8'h57 + i[7:0], {2'b01, d});
        end
        wr(8'h57, 16'h8000);
        wr(8'h58, 16'h2000);
        wr(8'h59, 16'h1000);
        wr(8'he0, 16'h0001);
        vin(16'h2000);
        rd(8'h5a, {2'b11, 16'h0080});
        vin(16'h1fff);
        rd(8'h5a, {2'b01, 16'h0080});
        for (i = 0; i < 8; i++) begin
            wr(8'h5a, {8'h00, cases[i][7:0]});
            vin(16'h0fff);
            repeat (100) @(posedge sys_clk);
            rd(8'h5a, {1'b0, cases[i][9], 8'h00, cases[i][7:0]});
            if (i == 0) rd(8'h7c, {2'b01, 16'h0030});
            vin(16'h3000);
            repeat (100) @(posedge sys_clk);
            rd(8'h5a, {1'b1, cases[i][8], 8'h00, cases[i][7:0]});
            wr(8'h03, 16'h0000);
            repeat (10) @(posedge sys_clk);
            rd(8'h5a, {2'b11, 8'h00, cases[i][7:0]});
        end
        vin(16'h0fff);
        vin(16'h3000);
        rd(8'h5a, {2'b10, 16'h00c0});
        wr(8'h7c, 16'h0010);
        repeat (10) @(posedge sys_clk);
        rd(8'h5a, {2'b11, 16'h00c0});
        vin(16'h0fff);
        vin(16'h3000);
        wr(8'h01, 16'h0000);
        repeat (10) @(posedge sys_clk);
        rd(8'h01, {2'b10, 16'h0000});
        wr(8'h01, 16'h0080);
        repeat (10) @(posedge sys_clk);
        rd(8'h5a, {2'b11, 16'h00c0});
        // control pin off then on releases the latch as well
        vin(16'h0fff);
        vin(16'h3000);
        run_pin = 1'b0;
        repeat (10) @(posedge sys_clk);
        rd(8'h5a, {2'b10, 16'h00c0});
        run_pin = 1'b1;
        repeat (10) @(posedge sys_clk);
        rd(8'h5a, {2'b11, 16'h00c0});
        wr(8'hd2, 16'h0001);
        rd(8'hd2, {2'b11, 16'h0001});
        repeat (4) @(posedge sys_clk);
        close_out;
    end
endmodule
